// ===== core/smb_regs.svh
`ifndef SMB_REGS_SVH
`define SMB_REGS_SVH

// Register byte offsets.
`define SMB_CTRL_OFS        8'h00
`define SMB_DIV_OFS         8'h04
`define SMB_CMD_OFS         8'h08
`define SMB_DATA_OFS        8'h0C

// Control register bit positions.
`define SMB_CTRL_EN_BIT      0
`define SMB_CTRL_STRETCH_BIT 1
`define SMB_CTRL_TOE_BIT     2
`define SMB_CTRL_FTE_BIT     3

// Command/status register bit positions.
`define SMB_CMD_BEGIN_BIT    0
`define SMB_CMD_HALT_BIT     1
`define SMB_CMD_ACK_BIT      2
`define SMB_CMD_CLR_BIT      3
`define SMB_ST_ACKPEND_BIT   0
`define SMB_ST_ARB_BIT       1
`define SMB_ST_ACKRX_BIT     2
`define SMB_ST_EVENT_BIT     3
`define SMB_ST_VEC_LSB       4
`define SMB_ST_BUSY_BIT      8
`define SMB_ST_FULL_BIT      9

// Reset values.
`define SMB_CTRL_RST        4'h0
`define SMB_DIV_RST         16'h0040
`define SMB_VEC_RST         4'h0

// Status vectors.
`define SMB_VEC_START       4'hE
`define SMB_VEC_MTX         4'hC

// Timing counts in system clocks, except the bus-free count, which is in divider periods.
`define SMB_HOLD_NORM       16'h0003
`define SMB_HOLD_EXT        16'h000C
`define SMB_SETUP_NORM      16'h0004
`define SMB_SETUP_EXT       16'h000B
`define SMB_HIGH_MIN        16'h0004
`define SMB_FREE_PERIODS    4'hA

`endif

// ===== core/smb_pkg.sv
package smb_pkg;

   typedef enum logic [3:0] {
      SMB_IDLE,
      SMB_START_A,
      SMB_START_B,
      SMB_RS_LOW,
      SMB_LOW,
      SMB_HIGH,
      SMB_WAIT,
      SMB_STOP_A,
      SMB_STOP_B,
      SMB_STOP_C
   } smb_state_t;

   typedef struct packed {
      smb_state_t  st;
      logic [15:0] cnt;
      logic [3:0]  bitn;
      logic [7:0]  shift;
      logic        sda_out;
      logic        scl_out;
      logic        event_flag;
      logic [3:0]  vec;
      logic        ack_rx;
      logic        arb;
      logic        begin_req;
      logic        halt_req;
      logic        ack_val;
      logic [3:0]  ctrl;
      logic [15:0] div;
      logic [15:0] src_cnt;
      logic [3:0]  free_cnt;
      logic        rd_ack;
      logic [31:0] rdata;
   } smb_core_t;

   typedef struct packed {
      logic [3:0] wr_ptr;
      logic [3:0] rd_ptr;
      logic [4:0] count;
   } smb_fifo_t;

endpackage : smb_pkg

// ===== core/smb_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none

interface smb_fifo_if;
   logic       push_valid;
   logic       push_ready;
   logic [7:0] push_data;
   logic       pop_valid;
   logic       pop_ready;
   logic [7:0] pop_data;

   modport store (
      input  push_valid,
      output push_ready,
      input  push_data,
      output pop_valid,
      input  pop_ready,
      output pop_data
   );

   modport user (
      output push_valid,
      input  push_ready,
      output push_data,
      input  pop_valid,
      output pop_ready,
      input  pop_data
   );
endinterface : smb_fifo_if

`default_nettype wire

// ===== core/smb_sync.sv
`timescale 1ns/1ps
`default_nettype none

module smb_sync #(
   parameter int W = 2
) (
   input  wire logic         sys_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   // Lines idle high, so reset to the released level.
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge sys_clk_i) begin
            if (sys_rst_i) begin
               meta_reg[g] <= 1'b1;
               sync_reg[g] <= 1'b1;
            end else begin
               meta_reg[g] <= async_i[g];
               sync_reg[g] <= meta_reg[g];
            end
         end
      end
   endgenerate

   assign sync_o = sync_reg;
endmodule : smb_sync

`default_nettype wire

// ===== core/smb_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module smb_fifo
   import smb_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic sys_clk_i,
   input  wire logic sys_rst_i,
   smb_fifo_if.store f
);
   logic [WIDTH-1:0] mem [DEPTH];
   smb_fifo_t        s_reg;
   smb_fifo_t        s_next;
   logic             do_push;
   logic             do_pop;

   assign f.push_ready = (s_reg.count != 5'(DEPTH));
   assign f.pop_valid  = (s_reg.count != 5'h0_0);
   assign f.pop_data   = mem[s_reg.rd_ptr];
   assign do_push      = f.push_valid && f.push_ready;
   assign do_pop       = f.pop_ready && f.pop_valid;

   always_comb begin
      s_next = s_reg;
      if (do_push) begin
         s_next.wr_ptr = s_reg.wr_ptr + 4'h1;
      end
      if (do_pop) begin
         s_next.rd_ptr = s_reg.rd_ptr + 4'h1;
      end
      s_next.count = s_reg.count + 5'(do_push) - 5'(do_pop);
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
      if (do_push) begin
         mem[s_reg.wr_ptr] <= f.push_data;
      end
   end
endmodule : smb_fifo

`default_nettype wire

// ===== core/smb_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "smb_regs.svh"

module smb_master
   import smb_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [7:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe_n_o,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n_o,
   output logic             timer_reload_o,
   output logic             timer_count_o
);
   smb_core_t   c_reg;
   smb_core_t   c_next;
   smb_fifo_if  fq ();
   logic [1:0]  pins_s;
   logic        scl_s;
   logic        sda_s;
   logic        en;
   logic        stretch;
   logic [15:0] low_len;
   logic [15:0] high_len;
   logic [15:0] hold_pt;
   logic [15:0] low_min;
   logic [31:0] bmask;
   logic        wr_ctrl;
   logic        wr_div;
   logic        wr_cmd;
   logic        wr_data;
   logic        src_tick;
   logic        lines_high;
   logic        bus_free;
   logic        data_full_stall;
   logic [31:0] rd_mux;

   smb_sync #(
      .W (2)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   ({scl_i, sda_i}),
      .sync_o    (pins_s)
   );

   smb_fifo #(
      .WIDTH (8),
      .DEPTH (16)
   ) u_fifo (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .f         (fq.store)
   );

   assign scl_s   = pins_s[1];
   assign sda_s   = pins_s[0];
   assign en      = c_reg.ctrl[`SMB_CTRL_EN_BIT];
   assign stretch = c_reg.ctrl[`SMB_CTRL_STRETCH_BIT];

   assign hold_pt  = stretch ? `SMB_HOLD_EXT : `SMB_HOLD_NORM;
   // The low phase is widened so hold plus setup always fit inside it.
   assign low_min  = stretch ? (`SMB_HOLD_EXT + `SMB_SETUP_EXT)
                             : (`SMB_HOLD_NORM + `SMB_SETUP_NORM + 16'h0001);
   assign low_len  = (c_reg.div > low_min) ? c_reg.div : low_min;
   assign high_len = (c_reg.div > `SMB_HIGH_MIN) ? c_reg.div : `SMB_HIGH_MIN;

   // Byte-lane mask for partial writes.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         bmask[i*8 +: 8] = {8{avs_byteenable_i[i]}};
      end
   end

   // Data writes stall on a full queue so no byte is ever dropped.
   assign data_full_stall = avs_write_i && (avs_address_i == `SMB_DATA_OFS) && !fq.push_ready;
   assign avs_waitrequest_o = (avs_read_i && !c_reg.rd_ack) || data_full_stall;
   assign avs_readdata_o    = c_reg.rdata;

   assign wr_ctrl = avs_write_i && (avs_address_i == `SMB_CTRL_OFS);
   assign wr_div  = avs_write_i && (avs_address_i == `SMB_DIV_OFS);
   assign wr_cmd  = avs_write_i && (avs_address_i == `SMB_CMD_OFS) && avs_byteenable_i[0];
   assign wr_data = avs_write_i && (avs_address_i == `SMB_DATA_OFS) && avs_byteenable_i[0];

   assign fq.push_valid = wr_data;
   assign fq.push_data  = avs_writedata_i[7:0];

   // Clock-source period comes from the divider register.
   assign src_tick   = (c_reg.src_cnt == 16'h0000);
   assign lines_high = scl_s && sda_s;
   // bus free after more than ten periods
   assign bus_free   = c_reg.ctrl[`SMB_CTRL_FTE_BIT]
                       ? (c_reg.free_cnt > `SMB_FREE_PERIODS) : lines_high;

   // timer reload while high, count while low
   assign timer_reload_o = en && c_reg.ctrl[`SMB_CTRL_TOE_BIT] && scl_s;
   assign timer_count_o  = en && c_reg.ctrl[`SMB_CTRL_TOE_BIT] && !scl_s;

   // Open-drain: enable is active low and the driven level is always low.
   assign scl_o      = 1'b0;
   assign sda_o      = 1'b0;
   assign scl_oe_n_o = c_reg.scl_out;
   assign sda_oe_n_o = c_reg.sda_out;

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address_i)
         `SMB_CTRL_OFS: rd_mux[3:0] = c_reg.ctrl;
         `SMB_DIV_OFS:  rd_mux[15:0] = c_reg.div;
         `SMB_CMD_OFS: begin
            rd_mux[`SMB_ST_ARB_BIT]   = c_reg.arb;
            rd_mux[`SMB_ST_ACKRX_BIT] = c_reg.ack_rx;
            rd_mux[`SMB_ST_EVENT_BIT] = c_reg.event_flag;
            rd_mux[`SMB_ST_VEC_LSB +: 4] = c_reg.vec;
            rd_mux[`SMB_ST_BUSY_BIT]  = (c_reg.st != SMB_IDLE);
            rd_mux[`SMB_ST_FULL_BIT]  = !fq.push_ready;
         end
         `SMB_DATA_OFS: rd_mux[7:0] = c_reg.shift;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      c_next       = c_reg;
      fq.pop_ready = 1'b0;

      // Register access.
      c_next.rd_ack = avs_read_i && !c_reg.rd_ack;
      if (avs_read_i && !c_reg.rd_ack) begin
         c_next.rdata = rd_mux;
      end
      if (wr_ctrl) begin
         c_next.ctrl = (c_reg.ctrl & ~bmask[3:0]) | (avs_writedata_i[3:0] & bmask[3:0]);
      end
      if (wr_div) begin
         c_next.div = (c_reg.div & ~bmask[15:0]) | (avs_writedata_i[15:0] & bmask[15:0]);
      end
      if (wr_cmd) begin
         c_next.begin_req = avs_writedata_i[`SMB_CMD_BEGIN_BIT];
         c_next.halt_req  = avs_writedata_i[`SMB_CMD_HALT_BIT];
         c_next.ack_val   = avs_writedata_i[`SMB_CMD_ACK_BIT];
         // clearing in the same write as the acknowledge makes the delay zero
         if (avs_writedata_i[`SMB_CMD_CLR_BIT]) begin
            c_next.event_flag = 1'b0;
         end
      end

      // Clock-source divider and idle-run counter.
      c_next.src_cnt = src_tick ? c_reg.div : c_reg.src_cnt - 16'h0001;
      if (!lines_high) begin
         c_next.free_cnt = 4'h0;
      end else if (src_tick && (c_reg.free_cnt != 4'hF)) begin
         c_next.free_cnt = c_reg.free_cnt + 4'h1;
      end

      c_next.cnt = c_reg.cnt + 16'h0001;
      unique case (c_reg.st)
         SMB_IDLE: begin
            c_next.scl_out = 1'b1;
            c_next.sda_out = 1'b1;
            c_next.cnt     = 16'h0000;
            if (en && c_reg.begin_req && bus_free) begin
               c_next.st = SMB_START_A;
            end
         end
         SMB_START_A: begin
            c_next.scl_out = 1'b1;
            c_next.sda_out = 1'b1;
            if (!scl_s) begin
               c_next.cnt = 16'h0000;
            end else if (c_reg.cnt >= high_len) begin
               c_next.st  = SMB_START_B;
               c_next.cnt = 16'h0000;
            end
         end
         SMB_START_B: begin
            c_next.sda_out = 1'b0;
            if (c_reg.cnt >= high_len) begin
               c_next.scl_out    = 1'b0;
               c_next.vec        = `SMB_VEC_START;
               c_next.arb        = 1'b0;
               c_next.begin_req  = 1'b0;
               c_next.event_flag = 1'b1;
               c_next.st         = SMB_WAIT;
               c_next.cnt        = 16'h0000;
            end
         end
         SMB_WAIT: begin
            // hold SCL low until the flag is cleared
            c_next.scl_out = 1'b0;
            c_next.cnt     = 16'h0000;
            if (!c_reg.event_flag) begin
               if (c_reg.halt_req) begin
                  c_next.st = SMB_STOP_A;
               end else if (c_reg.begin_req) begin
                  c_next.st = SMB_RS_LOW;
               end else if (fq.pop_valid) begin
                  fq.pop_ready = 1'b1;
                  c_next.shift = fq.pop_data;
                  c_next.bitn  = 4'h0;
                  c_next.st    = SMB_LOW;
               end
            end
         end
         SMB_RS_LOW: begin
            c_next.scl_out = 1'b0;
            if (c_reg.cnt == hold_pt) begin
               c_next.sda_out = 1'b1;
            end
            if (c_reg.cnt >= low_len) begin
               c_next.st  = SMB_START_A;
               c_next.cnt = 16'h0000;
            end
         end
         SMB_LOW: begin
            c_next.scl_out = 1'b0;
            // data changes only at the hold point
            // leaving setup of low time minus the hold point (3, or 12 when stretched)
            if (c_reg.cnt == hold_pt) begin
               c_next.sda_out = (c_reg.bitn == 4'h8) ? 1'b1 : c_reg.shift[7];
            end
            if (c_reg.cnt >= low_len) begin
               c_next.scl_out = 1'b1;
               c_next.st      = SMB_HIGH;
               c_next.cnt     = 16'h0000;
            end
         end
         SMB_HIGH: begin
            c_next.scl_out = 1'b1;
            if (!scl_s) begin
               // A slave stretching the clock restarts the high count.
               c_next.cnt = 16'h0000;
            end else if (c_reg.bitn != 4'h8 && c_reg.sda_out && !sda_s) begin
               c_next.arb        = 1'b1;
               c_next.sda_out    = 1'b1;
               c_next.vec        = `SMB_VEC_RST;
               c_next.event_flag = 1'b1;
               c_next.st         = SMB_IDLE;
            end else if (c_reg.cnt >= high_len) begin
               c_next.scl_out = 1'b0;
               c_next.cnt     = 16'h0000;
               if (c_reg.bitn == 4'h8) begin
                  c_next.ack_rx     = !sda_s;
                  c_next.vec        = `SMB_VEC_MTX;
                  c_next.event_flag = 1'b1;
                  c_next.st         = SMB_WAIT;
               end else begin
                  c_next.shift = {c_reg.shift[6:0], sda_s};
                  c_next.bitn  = c_reg.bitn + 4'h1;
                  c_next.st    = SMB_LOW;
               end
            end
         end
         SMB_STOP_A: begin
            c_next.scl_out = 1'b0;
            if (c_reg.cnt == hold_pt) begin
               c_next.sda_out = 1'b0;
            end
            if (c_reg.cnt >= low_len) begin
               c_next.st  = SMB_STOP_B;
               c_next.cnt = 16'h0000;
            end
         end
         SMB_STOP_B: begin
            c_next.scl_out = 1'b1;
            if (!scl_s) begin
               c_next.cnt = 16'h0000;
            end else if (c_reg.cnt >= high_len) begin
               c_next.st  = SMB_STOP_C;
               c_next.cnt = 16'h0000;
            end
         end
         SMB_STOP_C: begin
            c_next.sda_out = 1'b1;
            if (c_reg.cnt >= high_len) begin
               c_next.halt_req = 1'b0;
               c_next.vec      = `SMB_VEC_RST;
               c_next.st       = SMB_IDLE;
            end
         end
      endcase

      // disabling releases the bus at once so software can recover it.
      if (!en) begin
         c_next.st      = SMB_IDLE;
         c_next.scl_out = 1'b1;
         c_next.sda_out = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         c_reg         <= '0;
         c_reg.st      <= SMB_IDLE;
         c_reg.sda_out <= 1'b1;
         c_reg.scl_out <= 1'b1;
         c_reg.ctrl    <= `SMB_CTRL_RST;
         c_reg.div     <= `SMB_DIV_RST;
         c_reg.vec     <= `SMB_VEC_RST;
      end else begin
         c_reg <= c_next;
      end
   end
endmodule : smb_master

`default_nettype wire

// ===== testbench/smb_master_sva.sv
`timescale 1ns/1ps
`default_nettype none

module smb_master_sva (
   input wire logic        sys_clk_i,
   input wire logic        sys_rst_i,
   input wire logic [7:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0]  avs_byteenable_i,
   input wire logic        avs_waitrequest_o,
   input wire logic        scl_i,
   input wire logic        sda_i,
   input wire logic        scl_oe_n_o,
   input wire logic        sda_oe_n_o,
   input wire logic        timer_reload_o,
   input wire logic        timer_count_o
);
   logic [3:0]  ctrl_q;
   logic [15:0] div_q;
   logic [19:0] hi_cnt;
   logic        idle_q;
   logic        take;

   assign take = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];

   // Repeated starts skip the free check, so only starts after a stop, a release or reset count.
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ctrl_q <= 4'h0;
         div_q  <= 16'h0040;
         hi_cnt <= '0;
         idle_q <= 1'b1;
      end else begin
         if (take && avs_address_i == 8'h00) begin
            ctrl_q <= avs_writedata_i[3:0];
         end
         if (take && avs_address_i == 8'h04) begin
            div_q <= avs_writedata_i[15:0];
         end
         hi_cnt <= (scl_i && sda_i) ? hi_cnt + {19'h0_0000, ~&hi_cnt} : '0;
         if (scl_oe_n_o && sda_oe_n_o != $past(sda_oe_n_o)) begin
            idle_q <= sda_oe_n_o;
         end
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_scl_low11;
      !scl_oe_n_o [*8] ##1 !scl_oe_n_o [*3];
   endsequence
   sequence s_sda_keep12;
      $stable(sda_oe_n_o) [*8] ##1 $stable(sda_oe_n_o) [*4];
   endsequence

   property p_hold_ext;
      $fell(scl_oe_n_o) && ctrl_q[1] |-> s_sda_keep12;
   endproperty
   property p_setup_ext;
      $changed(sda_oe_n_o) && !scl_oe_n_o && ctrl_q[1] |-> s_scl_low11;
   endproperty
   property p_hold_norm;
      $fell(scl_oe_n_o) && !ctrl_q[1] |-> $stable(sda_oe_n_o) [*3];
   endproperty
   property p_reload;
      (ctrl_q[0] && ctrl_q[2] && scl_i) [*4] |-> timer_reload_o && !timer_count_o;
   endproperty
   property p_count;
      (ctrl_q[0] && ctrl_q[2] && !scl_i) [*4] |-> timer_count_o && !timer_reload_o;
   endproperty
   property p_timer_off;
      !ctrl_q[2] ##1 !ctrl_q[2] |-> !timer_reload_o && !timer_count_o;
   endproperty
   property p_idle;
      $fell(sda_oe_n_o) && scl_oe_n_o && ctrl_q[3] && idle_q |-> hi_cnt >= 10 * (div_q + 1);
   endproperty
   property p_rd_wait;
      $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
   endproperty

   a_hold_ext: assert property (p_hold_ext)
      else $error("SDA moved within 12 clocks of SCL falling");
   a_setup_ext: assert property (p_setup_ext)
      else $error("SCL rose within 11 clocks of SDA change");
   a_hold_norm: assert property (p_hold_norm)
      else $error("SDA moved within 3 clocks of SCL falling");
   a_reload: assert property (p_reload)
      else $error("Timer not reloading while SCL high");
   a_count: assert property (p_count)
      else $error("Timer not counting while SCL low");
   a_timer_off: assert property (p_timer_off)
      else $error("Timer controls active with timeout off");
   a_idle: assert property (p_idle)
      else $error("Start before bus idle time elapsed");
   a_rd_wait: assert property (p_rd_wait)
      else $error("Read wait sequence wrong");
endmodule // smb_master_sva

bind smb_master smb_master_sva u_sva (.sys_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
   .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o, .scl_i, .sda_i,
   .scl_oe_n_o, .sda_oe_n_o, .timer_reload_o, .timer_count_o);

`default_nettype wire

// ===== testbench/smb_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module smb_slave_model (
   input  wire logic  scl_i,
   input  wire logic  sda_i,
   input  wire logic  nack_i,
   output logic       pull_o,
   output logic [7:0] byte_o
);
   int         bit_n;
   logic [7:0] shift;
   logic       scl_q;

   // One process owns all model state, so no variable has two drivers.
   // A start or stop realigns the bit position, and the acknowledge covers
   // the whole ninth low phase, so a stalled SCL keeps it.
   initial begin
      pull_o = 1'b0;
      byte_o = 8'h00;
      shift  = 8'h00;
      bit_n  = 0;
      scl_q  = 1'b1;
      forever begin
         @(scl_i or sda_i);
         if (scl_i === 1'b1 && scl_q !== 1'b1) begin
            if (bit_n < 8) begin
               shift = {shift[6:0], sda_i};
            end
            bit_n = bit_n + 1;
            if (bit_n == 8) begin
               byte_o = shift;
            end
         end else if (scl_i === 1'b0 && scl_q === 1'b1) begin
            pull_o = (bit_n == 8) && !nack_i;
            if (bit_n == 9) begin
               bit_n = 0;
            end
         end else if (scl_i === 1'b1) begin
            bit_n = 0;
         end
         scl_q = scl_i;
      end
   end
endmodule // smb_slave_model

`default_nettype wire

// ===== testbench/test_smb_master.sv
`timescale 1ns/1ps
`default_nettype none

module test_smb_master;
   logic        clk, rst, rd, wr, wreq, nack, pull;
   logic        scl_oe_n, sda_oe_n, scl_o, sda_o, scl_w, sda_w, trl, tcn;
   logic [7:0]  adr, seen, b;
   logic [31:0] wdat, rdat, q, st;
   int          bad_count, n_tests, i;

   // Both lines have pull-ups, so a released line reads high.
   assign scl_w = scl_oe_n ? 1'b1 : scl_o;
   assign sda_w = (sda_oe_n ? 1'b1 : sda_o) & ~pull;

   always #4 clk = ~clk;

   smb_master dut (.sys_clk_i(clk), .sys_rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
      .timer_reload_o(trl), .timer_count_o(tcn));

   smb_slave_model far (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack), .pull_o(pull),
      .byte_o(seen));

   task automatic test_done;
      if (bad_count == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      rd   <= !w;
      wr   <= w;
      adr  <= a;
      wdat <= d;
      // The request stands until waitrequest is sampled low at a rising edge.
      do begin
         @(posedge clk);
         k++;
      end while (wreq !== 1'b0 && k < 300);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (wreq !== 1'b0) begin
         bad_count++;
         $display("MISMATCH %0t bus wait timed out", $time);
         test_done();
      end
   endtask

   // Polls status until the event flag shows, then checks vector, flag and clear bits.
   task automatic ev(input logic [3:0] v);
      int k;
      k  = 0;
      st = '0;
      while (st[3] !== 1'b1 && k < 400) begin
         bus(1'b0, 8'h08, '0);
         st = q;
         k++;
      end
      chk({st[7:3], st[1:0]}, {v, 3'b100});
      if (st[3] !== 1'b1)
         test_done();
   endtask

   initial begin
      clk       = 1'b0;
      rst       = 1'b1;
      rd        = 1'b0;
      wr        = 1'b0;
      adr       = 8'h00;
      wdat      = '0;
      nack      = 1'b0;
      bad_count = 0;
      n_tests   = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 8'h00, '0);
      chk(q, '0);
      bus(1'b0, 8'h04, '0);
      chk(q, 32'h0000_0040);
      bus(1'b1, 8'h10, 32'hFFFF_FFFF);
      bus(1'b0, 8'h10, '0);
      chk(q, '0);
      bus(1'b1, 8'h04, 32'h0000_0004);
      bus(1'b1, 8'h00, 32'h0000_0005);
      for (i = 0; i < 16; i++) begin
         b = 8'hA4 + 8'(i * 29);
         bus(1'b1, 8'h0C, {24'h00_0000, b});
      end
      bus(1'b0, 8'h08, '0);
      chk(q[9], 1'b1);
      bus(1'b1, 8'h08, 32'h0000_0001);
      ev(4'hE);
      for (i = 0; i < 16; i++) begin
         b = 8'hA4 + 8'(i * 29);
         bus(1'b1, 8'h08, 32'h0000_0008);
         ev(4'hC);
         chk(st[2], 1'b1);
         chk(seen, b);
         chk(scl_w, 1'b0);
      end
      nack <= 1'b1;
      bus(1'b1, 8'h0C, 32'h0000_003C);
      bus(1'b1, 8'h08, 32'h0000_0008);
      ev(4'hC);
      chk(st[2], 1'b0);
      nack <= 1'b0;
      bus(1'b1, 8'h08, 32'h0000_0009);
      ev(4'hE);
      bus(1'b1, 8'h00, 32'h0000_0007);
      bus(1'b1, 8'h0C, 32'h0000_00C3);
      bus(1'b1, 8'h08, 32'h0000_000C);
      ev(4'hC);
      chk(seen, 8'hC3);
      bus(1'b1, 8'h00, 32'h0000_000F);
      bus(1'b1, 8'h08, 32'h0000_000B);
      ev(4'hE);
      bus(1'b1, 8'h08, 32'h0000_000A);
      i = 0;
      do begin
         bus(1'b0, 8'h08, '0);
         i++;
      end while (q[8] !== 1'b0 && i < 100);
      chk(q[8], 1'b0);
      chk(q[7:4], 4'h0);
      chk({scl_w, sda_w}, 2'b11);
      bus(1'b1, 8'h08, 32'h0000_0001);
      ev(4'hE);
      // The stall outlasts the extended hold before the bus is dropped.
      repeat (4) bus(1'b0, 8'h08, '0);
      chk({trl, tcn}, 2'b01);
      // this stall stands for an overflow
      bus(1'b1, 8'h00, 32'h0000_000E);
      bus(1'b0, 8'h08, '0);
      chk({q[8], scl_w, sda_w, trl, tcn}, 5'h0C);
      bus(1'b1, 8'h00, 32'h0000_000F);
      bus(1'b0, 8'h00, '0);
      chk({q[3:0], trl, tcn}, 6'h3E);
      test_done();
   end
endmodule // test_smb_master

`default_nettype wire
